/* File: bench/hcw_core_model.sv */
module hcw_core_model (
    input wire logic clk_in,
    input wire logic clear_imask_in,
    input wire logic wake_in,
    output logic op_valid_out,
    output logic [7:0] op_out,
    output logic irq_out,
    output logic imask_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle core, interrupts masked
    initial
    begin
        op_valid_out = 1'b0;
        op_out = 8'h00;
        irq_out = 1'b0;
        imask_out = 1'b1;
    end
    // halt clears the mask, servicing the wake sets it again
    always @(posedge clk_in)
        if (clear_imask_in)
            imask_out <= 1'b0;
        else if (wake_in)
            imask_out <= 1'b1;
    // one executed opcode; inverted data once not valid
    task automatic exec(input logic [7:0] op);
        @(posedge clk_in);
        op_valid_out <= 1'b1;
        op_out <= op;
        @(posedge clk_in);
        op_valid_out <= 1'b0;
        op_out <= ~op;
    endtask
    // external interrupt pin level
    task automatic irq(input logic v);
        @(posedge clk_in);
        irq_out <= v;
    endtask
endmodule

/* File: bench/hcw_ctrl_properties.sv */
module hcw_ctrl_checker (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic opcode_valid_in,
    input wire logic [7:0] opcode_in,
    input wire logic cpu_clk_out,
    input wire logic periph_clk_out,
    input wire logic usb_clk_out,
    input wire logic osc_run_out,
    input wire logic clear_imask_out,
    input wire logic sys_reset_req_out,
    input wire logic irq_wake_out,
    input wire logic halted_out
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);
    // halt opcode taken while running
    sequence halt_taken;
        opcode_valid_in && opcode_in == 8'h8e && !halted_out;
    endsequence
    // oscillator stopped, mask cleared
    sequence halt_entered;
        halted_out && !osc_run_out && clear_imask_out;
    endsequence
    // reset request in place of a halt
    sequence halt_reset;
        sys_reset_req_out && !halted_out && !clear_imask_out;
    endsequence
    chk_apb_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out)
        else $error("apb answer late");
    chk_err_ready: assert property (pslverr_out |-> pready_out)
        else $error("error without ready");
    chk_periph_same: assert property (periph_clk_out == cpu_clk_out)
        else $error("peripheral clock differs");
    chk_halt_entry: assert property (halt_taken |=> halt_entered or halt_reset)
        else $error("halt not handled");
    chk_other_opcode: assert property
        (opcode_valid_in && opcode_in != 8'h8e |=> !clear_imask_out)
        else $error("non halt opcode halted");
    chk_halt_frozen: assert property (halted_out |-> !sys_reset_req_out && !osc_run_out)
        else $error("reset or oscillator in halt");
    chk_clk_stopped: assert property (!osc_run_out |-> !cpu_clk_out && !usb_clk_out)
        else $error("clock runs while stopped");
    chk_cpu_high: assert property ($fell(cpu_clk_out) && osc_run_out |-> $past(cpu_clk_out, 3))
        else $error("cpu high phase short");
    chk_cpu_low: assert property ($rose(cpu_clk_out) |-> !$past(cpu_clk_out, 3))
        else $error("cpu low phase short");
    chk_wake_soon: assert property ($rose(osc_run_out) |-> ##[2:16] irq_wake_out)
        else $error("wake late");
    chk_wake_clk: assert property (irq_wake_out |-> $past(cpu_clk_out) && osc_run_out)
        else $error("wake before clock");
endmodule

bind hcw_ctrl hcw_ctrl_checker hcw_ctrl_checker_inst (
    .ref_clk_in, .rst_in, .psel_in, .penable_in, .pready_out, .pslverr_out,
    .opcode_valid_in, .opcode_in, .cpu_clk_out, .periph_clk_out, .usb_clk_out,
    .osc_run_out, .clear_imask_out, .sys_reset_req_out, .irq_wake_out, .halted_out
);

/* File: bench/tb_top.sv */
`include "hcw_regs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import hcw_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    hcw_addr_t paddr = 8'h00;
    logic [31:0] pwd = 32'h0;
    logic opt = 1'b0;
    logic freq = 1'b1;
    logic rdy, err, erv, cpu, usb, osc, cim, srr, wake, hlt, opv, irq, imask;
    logic [31:0] prd, rdv;
    logic [7:0] op;
    logic [3:0] evs;
    int bad_count = 0;
    int checks_done = 0;
    int m_sms, k, c1, n0;
    int srr_n = 0;
    assign evs = {srr, usb, cpu, wake};
    always #12.5 clk = ~clk;
    // reset requests seen
    always @(posedge clk)
        if (srr === 1'b1)
            srr_n <= srr_n + 1;
    hcw_ctrl #(.WAKE_CPU_CYCLES(8), .WDG_PRESCALE(2)) hcw_ctrl_inst (
        .ref_clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwd), .pready_out(rdy),
        .prdata_out(prd), .pslverr_out(err), .opcode_valid_in(opv), .opcode_in(op),
        .halt_rst_opt_in(opt), .osc_freq_select_in(freq), .ext_irq_in(irq),
        .cpu_clk_out(cpu), .periph_clk_out(), .usb_clk_out(usb), .osc_run_out(osc),
        .clear_imask_out(cim), .sys_reset_req_out(srr), .irq_wake_out(wake),
        .halted_out(hlt));
    hcw_core_model hcw_core_model_inst (.clk_in(clk), .clear_imask_in(cim),
        .wake_in(wake), .op_valid_out(opv), .op_out(op), .irq_out(irq),
        .imask_out(imask));
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("FAIL at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // bounded wait for a level on one event line
    task automatic await(input int i, input logic v);
        for (k = 0; k < 3000 && evs[i] !== v; k++)
            @(posedge clk);
        if (k == 3000)
        begin
            bad_count++;
            complete_run();
        end
    endtask
    // length of one full high phase
    task automatic hi_len(input int i, input int exp);
        await(i, 1'b0);
        await(i, 1'b1);
        await(i, 1'b0);
        cmp(k, exp);
    endtask
    // apb transfer held until ready is sampled
    task automatic apb(input logic w, input hcw_addr_t a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (rdy !== 1'b1 && k < 50);
        rdv = prd;
        erv = err;
        psel <= 1'b0;
        pen <= 1'b0;
        if (k == 50)
        begin
            bad_count++;
            complete_run();
        end
    endtask
    task automatic rd(input hcw_addr_t a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, 32'h0);
        cmp(rdv, exp);
        cmp({31'h0, erv}, {31'h0, e});
    endtask
    task automatic do_rst();
        rst <= 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
    endtask
    // expected status word
    function automatic logic [31:0] st(input logic h);
        return {27'h0, freq, opt, ~h, 1'b0, h};
    endfunction
    initial
    begin
        rdv = $urandom(56);
        do_rst();
        rd(`HCW_OFF_STAT, st(0), 1'b0);
        rd(`HCW_OFF_WDG, 32'h7f, 1'b0);
        rd(8'h0c, 32'h0, 1'b1);
        apb(1'b1, `HCW_OFF_STAT, 32'h0);
        rd(`HCW_OFF_STAT, st(0), 1'b0);
        hi_len(1, 3);
        hi_len(2, 4);
        freq <= 1'b0;
        repeat (4) @(posedge clk);
        hi_len(2, 2);
        hi_len(1, 3);
        m_sms = 1;
        apb(1'b1, `HCW_OFF_CTRL, m_sms);
        rd(`HCW_OFF_CTRL, m_sms, 1'b0);
        hi_len(1, 3 * (1 + m_sms));
        apb(1'b1, `HCW_OFF_CTRL, 32'h0);
        repeat (4)
        begin
            hcw_core_model_inst.exec(8'($urandom_range(8'h8d, 8'h00)));
            @(posedge clk);
            cmp({cim, hlt}, 2'b00);
        end
        apb(1'b1, `HCW_OFF_WDG, 32'h80 | $urandom_range(8'h7f, 8'h50));
        hcw_core_model_inst.exec(`HCW_HALT_OPCODE);
        @(posedge clk);
        cmp({cim, hlt, osc}, 3'b110);
        apb(1'b0, `HCW_OFF_WDG, 32'h0);
        c1 = rdv;
        n0 = srr_n;
        cmp(imask, 1'b0);
        repeat (800) @(posedge clk);
        rd(`HCW_OFF_WDG, c1, 1'b0);
        rd(`HCW_OFF_STAT, st(1), 1'b0);
        cmp(srr_n, n0);
        hcw_core_model_inst.irq(1'b1);
        await(0, 1'b1);
        cmp(osc, 1'b1);
        rd(`HCW_OFF_WDG, c1, 1'b0);
        hcw_core_model_inst.irq(1'b0);
        await(3, 1'b1);
        cmp(32'(k >= 12 * (c1 - 192) + 16), 32'h1);
        do_rst();
        opt <= 1'b1;
        apb(1'b1, `HCW_OFF_WDG, 32'hff);
        hcw_core_model_inst.exec(`HCW_HALT_OPCODE);
        @(posedge clk);
        cmp({srr, hlt, cim}, 3'b100);
        do_rst();
        hcw_core_model_inst.exec(`HCW_HALT_OPCODE);
        @(posedge clk);
        cmp({srr, hlt, cim}, 3'b011);
        do_rst();
        rd(`HCW_OFF_WDG, 32'h7f, 1'b0);
        rd(`HCW_OFF_STAT, st(0), 1'b0);
        complete_run();
    end
endmodule

/* File: design/hcw_clk_div.sv */
module hcw_clk_div #(
    parameter int HALF_W = 4
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic run_in,
    input wire logic [HALF_W-1:0] half_in,
    output logic wave_out,
    output logic rise_out
);
    logic [HALF_W-1:0] cnt_q;
    logic wave_q;
    logic rise_q;

    generate
        if (HALF_W < 2)
        begin : g_chk
            $error("hcw_clk_div: HALF_W must be at least 2");
        end
    endgenerate

    // half-period counter; toggling every half gives an even duty cycle
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cnt_q <= '0;
            wave_q <= 1'b0;
            rise_q <= 1'b0;
        end
        else if (!run_in)
        begin
            cnt_q <= '0; // stopped oscillator parks the clock low
            wave_q <= 1'b0;
            rise_q <= 1'b0;
        end
        else if (cnt_q >= half_in - HALF_W'(1))
        begin
            cnt_q <= '0;
            wave_q <= !wave_q;
            rise_q <= !wave_q;
        end
        else
        begin
            cnt_q <= cnt_q + HALF_W'(1);
            rise_q <= 1'b0;
        end
    end

    assign wave_out = wave_q;
    assign rise_out = rise_q;
endmodule

/* File: design/hcw_ctrl.sv */
// Register access over APB and the register addresses were decided locally.
`include "hcw_regs.svh"

module hcw_ctrl #(
    parameter int WAKE_CPU_CYCLES = `HCW_WAKE_CYCLES,
    parameter int WDG_PRESCALE = `HCW_WDG_PRESCALE
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire hcw_pkg::hcw_addr_t paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic pready_out,
    output logic [31:0] prdata_out,
    output logic pslverr_out,
    input wire logic opcode_valid_in,
    input wire logic [7:0] opcode_in,
    input wire logic halt_rst_opt_in,
    input wire logic osc_freq_select_in,
    input wire logic ext_irq_in,
    output logic cpu_clk_out,
    output logic periph_clk_out,
    output logic usb_clk_out,
    output logic osc_run_out,
    output logic clear_imask_out,
    output logic sys_reset_req_out,
    output logic irq_wake_out,
    output logic halted_out
);
    import hcw_pkg::*;

    localparam int WAKE_W = $clog2(WAKE_CPU_CYCLES + 1);

    generate
        if (WAKE_CPU_CYCLES < 1)
        begin : g_chk
            $error("hcw_ctrl: WAKE_CPU_CYCLES must be at least 1");
        end
    endgenerate

    hcw_mode_e mode_q;
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic opt_s;
    logic freq_s;
    logic irq_s;
    logic sms_q;
    logic wdg_act_q;
    logic osc_run_q;
    logic halted_q;
    logic wake_first_q;
    logic [WAKE_W-1:0] wake_cnt_q;
    logic clear_imask_q;
    logic sys_reset_q;
    logic irq_wake_q;
    logic pready_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic [3:0] cpu_half;
    logic [3:0] usb_half;
    logic cpu_wave;
    logic cpu_rise;
    logic usb_wave;
    logic [6:0] wdg_cnt;
    logic wdg_expire;
    logic halt_exec;
    logic halt_rst;
    logic halt_go;
    logic acc;
    logic done;
    logic wr_ctrl;
    logic wr_wdg;
    logic [31:0] rd_mux;

    // true for the three mapped word offsets
    function automatic logic addr_hit(input hcw_addr_t a);
        addr_hit = (a == `HCW_OFF_CTRL) || (a == `HCW_OFF_WDG) || (a == `HCW_OFF_STAT);
    endfunction

    // two-flop synchronisers for the option strap, frequency strap and irq pin
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
        end
        else
        begin
            sync1_q <= {ext_irq_in, osc_freq_select_in, halt_rst_opt_in};
            sync2_q <= sync1_q;
        end
    end

    assign opt_s = sync2_q[0];
    assign freq_s = sync2_q[1];
    assign irq_s = sync2_q[2];

    // divider settings
    assign cpu_half = sms_q ? 4'(`HCW_CPU_DIV * `HCW_SMS_FACTOR) : `HCW_CPU_DIV;
    assign usb_half = freq_s ? `HCW_USB_DIV_24 : `HCW_USB_DIV_12;

    // cpu clock, gated by the oscillator run state
    hcw_clk_div #(
        .HALF_W(4)
    ) u_cpu_div (
        .clk_in(ref_clk_in),
        .rst_in(rst_in),
        .run_in(osc_run_q && !halt_go),
        .half_in(cpu_half),
        .wave_out(cpu_wave),
        .rise_out(cpu_rise)
    );

    // usb clock from the same oscillator
    hcw_clk_div #(
        .HALF_W(4)
    ) u_usb_div (
        .clk_in(ref_clk_in),
        .rst_in(rst_in),
        .run_in(osc_run_q && !halt_go),
        .half_in(usb_half),
        .wave_out(usb_wave),
        .rise_out()
    );

    // watchdog counter, frozen outside run mode
    hcw_wdg #(
        .PRESCALE(WDG_PRESCALE)
    ) u_wdg (
        .clk_in(ref_clk_in),
        .rst_in(rst_in),
        .tick_in(cpu_rise),
        .freeze_in(mode_q != HCW_RUN),
        .active_in(wdg_act_q),
        .load_in(wr_wdg),
        .load_val_in(pwdata_in[`HCW_WDG_CNT_MSB:0]),
        .count_out(wdg_cnt),
        .expire_out(wdg_expire)
    );

    // halt decode from the core's executed opcode
    assign halt_exec = opcode_valid_in && (opcode_in == `HCW_HALT_OPCODE)
        && (mode_q != HCW_HALT);
    assign halt_rst = halt_exec && opt_s && wdg_act_q;
    assign halt_go = halt_exec && !halt_rst;

    // power mode sequencing
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            mode_q <= HCW_RUN;
            wake_cnt_q <= '0;
        end
        else
        begin
            case (mode_q)
                HCW_RUN:
                begin
                    if (halt_go)
                        mode_q <= HCW_HALT;
                end
                HCW_HALT:
                begin
                    if (irq_s)
                    begin
                        mode_q <= HCW_WAKE;
                        wake_cnt_q <= '0;
                    end
                end
                HCW_WAKE:
                begin
                    if (halt_go)
                        mode_q <= HCW_HALT;
                    else if (cpu_rise)
                    begin
                        wake_cnt_q <= wake_cnt_q + WAKE_W'(1);
                        if (wake_cnt_q == WAKE_W'(WAKE_CPU_CYCLES - 1))
                            mode_q <= HCW_RUN;
                    end
                end
                default:
                    mode_q <= HCW_RUN;
            endcase
        end
    end

    // oscillator run state and halt flag: stopped by halt, restarted by the wake interrupt
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            osc_run_q <= 1'b1;
            halted_q <= 1'b0;
        end
        else if (halt_go)
        begin
            osc_run_q <= 1'b0;
            halted_q <= 1'b1;
        end
        else if (mode_q == HCW_HALT && irq_s)
        begin
            osc_run_q <= 1'b1;
            halted_q <= 1'b0;
        end
    end

    // interrupt released to the core only after the first cpu clock edge
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wake_first_q <= 1'b0;
            irq_wake_q <= 1'b0;
        end
        else
        begin
            irq_wake_q <= wake_first_q && cpu_rise;
            if (mode_q == HCW_HALT && irq_s)
                wake_first_q <= 1'b1;
            else if (cpu_rise || halt_go)
                wake_first_q <= 1'b0;
        end
    end

    // one-cycle pulses to the core and the reset controller
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            clear_imask_q <= 1'b0;
            sys_reset_q <= 1'b0;
        end
        else
        begin
            clear_imask_q <= halt_go;
            sys_reset_q <= halt_rst || (wdg_expire && mode_q == HCW_RUN && !halt_go);
        end
    end

    // apb access phase; pready comes one cycle after the access starts
    assign acc = psel_in && penable_in;
    assign done = acc && pready_q;
    assign wr_ctrl = done && pwrite_in && (paddr_in == `HCW_OFF_CTRL);
    assign wr_wdg = done && pwrite_in && (paddr_in == `HCW_OFF_WDG);

    // read data selection
    always_comb
    begin
        rd_mux = 32'h0;
        case (paddr_in)
            `HCW_OFF_CTRL:
                rd_mux[`HCW_CTRL_SMS_BIT] = sms_q;
            `HCW_OFF_WDG:
            begin
                rd_mux[`HCW_WDG_ACT_BIT] = wdg_act_q;
                rd_mux[`HCW_WDG_CNT_MSB:0] = wdg_cnt;
            end
            `HCW_OFF_STAT:
            begin
                rd_mux[`HCW_STAT_HALT_BIT] = (mode_q == HCW_HALT);
                rd_mux[`HCW_STAT_WAKE_BIT] = (mode_q == HCW_WAKE);
                rd_mux[`HCW_STAT_OSC_BIT] = osc_run_q;
                rd_mux[`HCW_STAT_OPT_BIT] = opt_s;
                rd_mux[`HCW_STAT_FREQ_BIT] = freq_s;
            end
            default:
                rd_mux = 32'h0;
        endcase
    end

    // apb answer registers
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q <= acc && !pready_q;
            pslverr_q <= acc && !pready_q && !addr_hit(paddr_in);
            prdata_q <= (acc && !pready_q && !pwrite_in) ? rd_mux : 32'h0;
        end
    end

    // slow mode select
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
            sms_q <= 1'b0;
        else if (wr_ctrl)
            sms_q <= pwdata_in[`HCW_CTRL_SMS_BIT];
    end

    // watchdog active bit: software can only set it, reset clears it
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
            wdg_act_q <= 1'b0;
        else if (wr_wdg && pwdata_in[`HCW_WDG_ACT_BIT])
            wdg_act_q <= 1'b1;
    end

    assign cpu_clk_out = cpu_wave;
    assign periph_clk_out = cpu_wave;
    assign usb_clk_out = usb_wave;
    assign osc_run_out = osc_run_q;
    assign clear_imask_out = clear_imask_q;
    assign sys_reset_req_out = sys_reset_q;
    assign irq_wake_out = irq_wake_q;
    assign halted_out = halted_q;
    assign pready_out = pready_q;
    assign prdata_out = prdata_q;
    assign pslverr_out = pslverr_q;
endmodule

/* File: design/hcw_wdg.sv */
`include "hcw_regs.svh"
module hcw_wdg #(
    parameter int PRESCALE = `HCW_WDG_PRESCALE
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic tick_in,
    input wire logic freeze_in,
    input wire logic active_in,
    input wire logic load_in,
    input wire logic [6:0] load_val_in,
    output logic [6:0] count_out,
    output logic expire_out
);
    localparam int PW = $clog2(PRESCALE + 1);

    logic [PW-1:0] pre_q;
    logic [6:0] count_q;
    logic expire_q;
    logic step;

    generate
        if (PRESCALE < 1)
        begin : g_chk
            $error("hcw_wdg: PRESCALE must be at least 1");
        end
    endgenerate

    // one count step per prescale cpu clocks, none while frozen
    assign step = active_in && !freeze_in && tick_in && (pre_q == PW'(PRESCALE - 1));

    // prescaler runs on cpu clocks only while counting is allowed
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            pre_q <= '0;
        else if (load_in || step)
            pre_q <= '0;
        else if (active_in && !freeze_in && tick_in)
            pre_q <= pre_q + PW'(1);
    end

    // down counter; a reset is asked when the top bit would fall
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            count_q <= `HCW_WDG_CNT_RST;
            expire_q <= 1'b0;
        end
        else
        begin
            expire_q <= step && (count_q == `HCW_WDG_CNT_LIMIT);
            if (load_in)
                count_q <= load_val_in;
            else if (step)
                count_q <= count_q - 7'h01;
        end
    end

    assign count_out = count_q;
    assign expire_out = expire_q;
endmodule

/* File: include/hcw_pkg.sv */
package hcw_pkg;

    // apb byte address
    typedef logic [7:0] hcw_addr_t;

    // power mode of the core clock tree
    typedef enum {HCW_RUN, HCW_HALT, HCW_WAKE} hcw_mode_e;

endpackage

/* File: include/hcw_regs.svh */
`ifndef HCW_REGS_SVH
`define HCW_REGS_SVH

// register byte offsets on the apb bus
`define HCW_OFF_CTRL 8'h00
`define HCW_OFF_WDG 8'h04
`define HCW_OFF_STAT 8'h08

// control register fields
`define HCW_CTRL_SMS_BIT 0

// watchdog register fields and reset value
`define HCW_WDG_ACT_BIT 7
`define HCW_WDG_CNT_MSB 6
`define HCW_WDG_CNT_RST 7'h7f
`define HCW_WDG_CNT_LIMIT 7'h40

// status register fields
`define HCW_STAT_HALT_BIT 0
`define HCW_STAT_WAKE_BIT 1
`define HCW_STAT_OSC_BIT 2
`define HCW_STAT_OPT_BIT 3
`define HCW_STAT_FREQ_BIT 4

// halt opcode as decoded from the core
`define HCW_HALT_OPCODE 8'h8e

// divider half periods, counted in ref clock cycles; each clock toggles after that many ref cycles
`define HCW_CPU_DIV 4'h3
`define HCW_SMS_FACTOR 2
`define HCW_USB_DIV_24 4'h4
`define HCW_USB_DIV_12 4'h2

// cpu clocks the watchdog stays frozen after an interrupt wakeup
`define HCW_WAKE_CYCLES 4096
// cpu clocks per watchdog count step
`define HCW_WDG_PRESCALE 16

`endif
